//--- rsc_pkg.sv
// rsc_pkg: register map, field layout, reset values and carrier types of the receiver config bank
package rsc_pkg;
   // register offsets
   localparam logic [7:0] RSC_OFS_POLY_CFG = 8'h11;
   localparam logic [7:0] RSC_OFS_SYNC_CTL = 8'h12;
   localparam logic [7:0] RSC_OFS_RESV = 8'h13;
   localparam logic [7:0] RSC_OFS_RSSI = 8'h14;
   localparam logic [7:0] RSC_OFS_OOK_CFG = 8'h15;
   localparam logic [7:0] RSC_OFS_PAT_B3 = 8'h16;
   localparam logic [7:0] RSC_OFS_PAT_B2 = 8'h17;
   localparam logic [7:0] RSC_OFS_PAT_B1 = 8'h18;
   localparam logic [7:0] RSC_OFS_PAT_B0 = 8'h19;
   // reset values
   localparam logic [7:0] RSC_RST_POLY_CFG = 8'h38;
   localparam logic [7:0] RSC_RST_SYNC_CTL = 8'h18;
   localparam logic [7:0] RSC_RST_RESV = 8'h07;
   localparam logic [7:0] RSC_RST_OOK_CFG = 8'h00;
   localparam logic [7:0] RSC_RST_PAT = 8'h00;
   localparam logic [7:0] RSC_UNMAPPED_READ = 8'h00;
   // field positions
   localparam int RSC_POLY_CF_LSB = 4;
   localparam int RSC_POLY_RSV_LSB = 0;
   localparam int RSC_SYNC_FILT_BIT = 7;
   localparam int RSC_SYNC_BSOFF_BIT = 6;
   localparam int RSC_SYNC_REC_BIT = 5;
   localparam int RSC_SYNC_LEN_LSB = 3;
   localparam int RSC_SYNC_TOL_LSB = 1;
   localparam int RSC_SYNC_RSV_BIT = 0;
   localparam int RSC_OOK_STEP_LSB = 5;
   localparam int RSC_OOK_PER_LSB = 2;
   localparam int RSC_OOK_AVG_LSB = 0;
   // pattern length codes
   localparam logic [1:0] RSC_LEN_8 = 2'h0;
   localparam logic [1:0] RSC_LEN_16 = 2'h1;
   localparam logic [1:0] RSC_LEN_24 = 2'h2;
   localparam logic [1:0] RSC_LEN_32 = 2'h3;
   localparam int RSC_PAT_BITS = 32;
   // averaging cutoff codes, the middle two are reserved
   localparam logic [1:0] RSC_AVG_BR_8PI = 2'h0;
   localparam logic [1:0] RSC_AVG_BR_32PI = 2'h3;
   // threshold step in half-dB units, indexed by step code
   localparam logic [3:0] RSC_STEP_HALF_DB [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC};

   // controls handed to the demodulator datapath
   typedef struct packed {
      logic [3:0] poly_center_freq_sel;
      logic poly_filter_on;
      logic bit_synchronizer_off;
      logic [3:0] keying_step_half_db;
      logic [2:0] keying_threshold_period;
      logic keying_period_is_multi;
      logic [3:0] keying_period_log2;
      logic keying_average_wide;
   } rsc_ctl_t;

   // sync detector settings
   typedef struct packed {
      logic pattern_recognition_on;
      logic [1:0] pattern_length_sel;
      logic [1:0] pattern_error_tolerance;
      logic [31:0] pattern_value;
   } rsc_sync_cfg_t;
endpackage

//--- rsc_rssi_hold.sv
// rsc_rssi_hold: two-stage capture of the live signal strength measurement
`timescale 1ns/1ps
`default_nettype none
module rsc_rssi_hold
   import rsc_pkg::*;
(
   // clock
   input wire logic mclk,
   // measurement from the analog front end, asynchronous
   input wire logic [7:0] meas_in,
   // held value
   output logic [7:0] meas_q
);
   logic [7:0] meas_s1_q;

   // no reset on purpose: the value only mirrors the live measurement
   always_ff @(posedge mclk) begin
      meas_s1_q <= meas_in;
      meas_q <= meas_s1_q;
   end
endmodule
`default_nettype wire

//--- rsc_sync_match.sv
// rsc_sync_match: tolerant comparison of the received bit window with the stored pattern
`timescale 1ns/1ps
`default_nettype none
module rsc_sync_match
   import rsc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // settings and received bits
   input wire rsc_sync_cfg_t cfg,
   input wire logic bit_valid,
   input wire logic bit_value,
   // result
   output logic match_q
);
   logic [31:0] shift_q;
   logic [31:0] diff;
   logic [31:0] care;
   logic [5:0] err_cnt;
   logic [5:0] tol;

   // newest bit enters at bit 0; the oldest received aligns with pattern bit 31
   always_ff @(posedge mclk) begin
      if (reset) begin
         shift_q <= 32'h00000000;
      end else if (bit_valid) begin
         shift_q <= {shift_q[30:0], bit_value};
      end
   end

   // shorter lengths use the top bytes of the pattern, compared with the newest received bits
   always_comb begin
      case (cfg.pattern_length_sel)
         RSC_LEN_8: begin
            diff = {shift_q[7:0] ^ cfg.pattern_value[31:24], 24'h000000};
            care = 32'hFF000000;
         end
         RSC_LEN_16: begin
            diff = {shift_q[15:0] ^ cfg.pattern_value[31:16], 16'h0000};
            care = 32'hFFFF0000;
         end
         RSC_LEN_24: begin
            diff = {shift_q[23:0] ^ cfg.pattern_value[31:8], 8'h00};
            care = 32'hFFFFFF00;
         end
         default: begin
            diff = shift_q ^ cfg.pattern_value;
            care = 32'hFFFFFFFF;
         end
      endcase
   end

   // population count of mismatches
   always_comb begin
      err_cnt = 6'h00;
      for (int i = 0; i < RSC_PAT_BITS; i++) begin
         err_cnt = err_cnt + {5'h00, diff[i] & care[i]};
      end
      tol = {4'h0, cfg.pattern_error_tolerance};
   end

   // match only while recognition is enabled and errors within tolerance
   always_ff @(posedge mclk) begin
      if (reset) begin
         match_q <= 1'b0;
      end else begin
         match_q <= cfg.pattern_recognition_on && bit_valid && (err_cnt <= tol);
      end
   end
endmodule
`default_nettype wire

//--- rsc_regs.sv
// rsc_regs: receiver configuration register bank with sync detector and rssi readout
//
// Operation
// - polyphase center select in bits 7:4 of the filter config, resets to 0011
// - sync control bit 7 set applies polyphase filter in on-off keyed receive
// - sync control bit 6 set turns bit synchronizer off; reset keeps it on
// - sync control bit 5 enables pattern recognition; reset off
// - length field bits 4:3: 11=32, 10=24, 01=16, 00=8 bits, reset 32
// - tolerance field bits 2:1 gives accepted mismatching bits, reset zero
// - reserved register 0x13 resets to 0x07 and must not become zero
// - read-only signal strength value at 0x14
// - signal strength has no reset value, always reflects live measurement
// - threshold step bits 7:5: 0.5,1,1.5,2,3,4,5,6 dB
// - threshold period bits 4:2: once per 1,2,4,8 chips or 2,4,8,16 per chip
// - averaging cutoff: 00 is rate over 8 pi, 11 rate over 32 pi, rest reserved
// - pattern bits 31:24 at 0x16, 23:16 at 0x17, read/write, reset zero
// - pattern bits 15:8 at 0x18, 7:0 at 0x19, reset zero
`timescale 1ns/1ps
`default_nettype none
module rsc_regs
   import rsc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // measurement and demodulated bit stream
   input wire logic [7:0] rssi_meas,
   input wire logic rx_bit_valid,
   input wire logic rx_bit_value,
   // controls towards the receive datapath
   output rsc_ctl_t rx_ctl,
   output logic sync_match,
   output logic cutoff_code_illegal
);
   logic [3:0] center_q;
   logic [3:0] poly_rsv_q;
   logic filt_on_q;
   logic bs_off_q;
   logic rec_on_q;
   logic [1:0] len_q;
   logic [1:0] tol_q;
   logic sync_rsv_q;
   logic [7:0] resv_q;
   logic [2:0] step_q;
   logic [2:0] period_q;
   logic [1:0] avg_q;
   logic [7:0] pat_q [4];
   logic [7:0] rssi_q;
   logic [7:0] rdata_d;
   rsc_sync_cfg_t sync_cfg;
   rsc_ctl_t ctl_d;

   // filter config writes; reserved low nibble stored as written
   always_ff @(posedge mclk) begin
      if (reset) begin
         center_q <= RSC_RST_POLY_CFG[7:4];
         poly_rsv_q <= RSC_RST_POLY_CFG[3:0];
      end else if (reg_wr && reg_addr == RSC_OFS_POLY_CFG) begin
         center_q <= reg_wdata[RSC_POLY_CF_LSB +: 4];
         poly_rsv_q <= reg_wdata[RSC_POLY_RSV_LSB +: 4];
      end
   end

   // sync control writes
   always_ff @(posedge mclk) begin
      if (reset) begin
         filt_on_q <= RSC_RST_SYNC_CTL[RSC_SYNC_FILT_BIT];
         bs_off_q <= RSC_RST_SYNC_CTL[RSC_SYNC_BSOFF_BIT];
         rec_on_q <= RSC_RST_SYNC_CTL[RSC_SYNC_REC_BIT];
         len_q <= RSC_RST_SYNC_CTL[RSC_SYNC_LEN_LSB +: 2];
         tol_q <= RSC_RST_SYNC_CTL[RSC_SYNC_TOL_LSB +: 2];
         sync_rsv_q <= RSC_RST_SYNC_CTL[RSC_SYNC_RSV_BIT];
      end else if (reg_wr && reg_addr == RSC_OFS_SYNC_CTL) begin
         filt_on_q <= reg_wdata[RSC_SYNC_FILT_BIT];
         bs_off_q <= reg_wdata[RSC_SYNC_BSOFF_BIT];
         rec_on_q <= reg_wdata[RSC_SYNC_REC_BIT];
         len_q <= reg_wdata[RSC_SYNC_LEN_LSB +: 2];
         tol_q <= reg_wdata[RSC_SYNC_TOL_LSB +: 2];
         sync_rsv_q <= reg_wdata[RSC_SYNC_RSV_BIT]; // kept as written, host keeps it 0
      end
   end

   // reserved register: a zero write is dropped so the non-zero content survives
   always_ff @(posedge mclk) begin
      if (reset) begin
         resv_q <= RSC_RST_RESV;
      end else if (reg_wr && reg_addr == RSC_OFS_RESV && reg_wdata != 8'h00) begin
         resv_q <= reg_wdata;
      end
   end

   // on-off keying threshold config
   always_ff @(posedge mclk) begin
      if (reset) begin
         step_q <= RSC_RST_OOK_CFG[RSC_OOK_STEP_LSB +: 3];
         period_q <= RSC_RST_OOK_CFG[RSC_OOK_PER_LSB +: 3];
         avg_q <= RSC_RST_OOK_CFG[RSC_OOK_AVG_LSB +: 2];
      end else if (reg_wr && reg_addr == RSC_OFS_OOK_CFG) begin
         step_q <= reg_wdata[RSC_OOK_STEP_LSB +: 3];
         period_q <= reg_wdata[RSC_OOK_PER_LSB +: 3];
         avg_q <= reg_wdata[RSC_OOK_AVG_LSB +: 2];
      end
   end

   // pattern bytes, index 3 holds bits 31:24 at the lowest offset
   for (genvar b = 0; b < 4; b++) begin : g_pat
      always_ff @(posedge mclk) begin
         if (reset) begin
            pat_q[b] <= RSC_RST_PAT;
         end else if (reg_wr && reg_addr == RSC_OFS_PAT_B3 + 8'(3 - b)) begin
            pat_q[b] <= reg_wdata;
         end
      end
   end

   // live signal strength, synchronised, never reset
   rsc_rssi_hold u_rssi (
      .mclk(mclk),
      .meas_in(rssi_meas),
      .meas_q(rssi_q)
   );

   // detector settings
   always_comb begin
      sync_cfg.pattern_recognition_on = rec_on_q;
      sync_cfg.pattern_length_sel = len_q;
      sync_cfg.pattern_error_tolerance = tol_q;
      sync_cfg.pattern_value = {pat_q[3], pat_q[2], pat_q[1], pat_q[0]};
   end

   rsc_sync_match u_match (
      .mclk(mclk),
      .reset(reset),
      .cfg(sync_cfg),
      .bit_valid(rx_bit_valid),
      .bit_value(rx_bit_value),
      .match_q(sync_match)
   );

   // read mux; unmapped offsets read zero
   always_comb begin
      case (reg_addr)
         RSC_OFS_POLY_CFG: rdata_d = {center_q, poly_rsv_q};
         RSC_OFS_SYNC_CTL: rdata_d = {filt_on_q, bs_off_q, rec_on_q, len_q, tol_q, sync_rsv_q};
         RSC_OFS_RESV: rdata_d = resv_q;
         RSC_OFS_RSSI: rdata_d = rssi_q;
         RSC_OFS_OOK_CFG: rdata_d = {step_q, period_q, avg_q};
         RSC_OFS_PAT_B3: rdata_d = pat_q[3];
         RSC_OFS_PAT_B2: rdata_d = pat_q[2];
         RSC_OFS_PAT_B1: rdata_d = pat_q[1];
         RSC_OFS_PAT_B0: rdata_d = pat_q[0];
         default: rdata_d = RSC_UNMAPPED_READ;
      endcase
   end

   // read data valid the cycle after the strobe only
   always_ff @(posedge mclk) begin
      if (reset) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // decoded datapath controls; period code bit 2 selects several decrements per chip
   always_comb begin
      ctl_d.poly_center_freq_sel = center_q;
      ctl_d.poly_filter_on = filt_on_q;
      ctl_d.bit_synchronizer_off = bs_off_q;
      ctl_d.keying_step_half_db = RSC_STEP_HALF_DB[step_q];
      ctl_d.keying_threshold_period = period_q;
      ctl_d.keying_period_is_multi = period_q[2];
      ctl_d.keying_period_log2 = period_q[2] ? {2'h0, period_q[1:0]} + 4'h1 : {2'h0, period_q[1:0]};
      ctl_d.keying_average_wide = (avg_q == RSC_AVG_BR_32PI);
   end

   // registered outputs
   always_ff @(posedge mclk) begin
      if (reset) begin
         rx_ctl <= '0;
         cutoff_code_illegal <= 1'b0;
      end else begin
         rx_ctl <= ctl_d;
         cutoff_code_illegal <= (avg_q != RSC_AVG_BR_8PI) && (avg_q != RSC_AVG_BR_32PI);
      end
   end
endmodule
`default_nettype wire

//--- rsc_regs_asserts.sv
// rsc_regs_asserts: port-level checks of the receiver config bank
`timescale 1ns/1ps
`default_nettype none
module rsc_regs_asserts
   import rsc_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic reset,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // stream and controls
   input wire logic rx_bit_valid,
   input wire rsc_ctl_t rx_ctl,
   input wire logic sync_match,
   input wire logic cutoff_code_illegal
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   logic [16:0] w1_q, w2_q;
   // write request delayed to the cycle where rx_ctl must show it; cleared so reset writes never count
   always_ff @(posedge mclk) begin
      if (reset) begin
         w1_q <= '0;
         w2_q <= '0;
      end else begin
         w1_q <= {reg_wr, reg_addr, reg_wdata};
         w2_q <= w1_q;
      end
   end
   readback_a:
      assert property (reg_rd && $past(reg_wr, 2) && $past(reg_addr, 2) == reg_addr
         && reg_addr inside {8'h11, 8'h12, [8'h15:8'h19]} |=> reg_rdata == $past(reg_wdata, 3))
      else $error("read back differs from write");
   resv_keep_a:
      assert property (reg_rd && reg_addr == RSC_OFS_RESV |=> reg_rdata != 8'h00) else $error("reserved read zero");
   center_lag_a:
      assert property (w2_q[16] && w2_q[15:8] == RSC_OFS_POLY_CFG |-> rx_ctl.poly_center_freq_sel == w2_q[7:4])
      else $error("center select wrong");
   ctl_bits_a:
      assert property (w2_q[16] && w2_q[15:8] == RSC_OFS_SYNC_CTL
         |-> {rx_ctl.poly_filter_on, rx_ctl.bit_synchronizer_off} == w2_q[7:6]) else $error("filter bits wrong");
   step_map_a:
      assert property (w2_q[16] && w2_q[15:8] == RSC_OFS_OOK_CFG |-> rx_ctl.keying_step_half_db ==
         (w2_q[7] ? {w2_q[6:5], 1'b0} + 4'h6 : {2'h0, w2_q[6:5]} + 4'h1)) else $error("step decode wrong");
   period_map_a:
      assert property (w2_q[16] && w2_q[15:8] == RSC_OFS_OOK_CFG |-> rx_ctl.keying_period_is_multi == w2_q[4]
         && rx_ctl.keying_period_log2 == {2'h0, w2_q[3:2]} + {3'h0, w2_q[4]}) else $error("period decode wrong");
   cutoff_flag_a:
      assert property (w2_q[16] && w2_q[15:8] == RSC_OFS_OOK_CFG |-> cutoff_code_illegal == ^w2_q[1:0])
      else $error("cutoff flag wrong");
   avg_wide_a:
      assert property (w2_q[16] && w2_q[15:8] == RSC_OFS_OOK_CFG |-> rx_ctl.keying_average_wide == &w2_q[1:0])
      else $error("average cutoff decode wrong");
   match_cause_a:
      assert property (sync_match |-> $past(rx_bit_valid)) else $error("match without bit strobe");
endmodule
bind rsc_regs rsc_regs_asserts rsc_regs_asserts_i (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_bit_valid(rx_bit_valid),
   .rx_ctl(rx_ctl), .sync_match(sync_match), .cutoff_code_illegal(cutoff_code_illegal));
`default_nettype wire

//--- rsc_host_model.sv
// rsc_host_model: host side driving the register port and the demodulated bit stream
`timescale 1ns/1ps
`default_nettype none
module rsc_host_model (
   // clock and read data
   input wire logic mclk,
   input wire logic [7:0] reg_rdata,
   // register port
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr,
   output logic reg_rd,
   // bit stream
   output logic rx_bit_valid,
   output logic rx_bit_value
);
   // idle lines at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      rx_bit_valid = 1'b0;
      rx_bit_value = 1'b0;
   end
   // callers keep reserved fields legal except in deliberate fault cases
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      #1 d = reg_rdata;
   endtask
   // n bits oldest first, then one extra strobe since the match lags a bit
   task automatic send(input logic [31:0] v, input int n);
      for (int i = n; i >= 0; i--) begin
         @(posedge mclk);
         rx_bit_valid <= 1'b1;
         rx_bit_value <= (i > 0) ? v[i - 1] : 1'b0;
      end
      @(posedge mclk);
      rx_bit_valid <= 1'b0;
      rx_bit_value <= 1'b1;
   endtask
endmodule
`default_nettype wire

//--- testbench.sv
// testbench: register map, control decode and pattern detector checks
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rsc_pkg::*;
   logic mclk, reset, reg_wr, reg_rd, rx_bit_valid, rx_bit_value, sync_match, cutoff_code_illegal;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rssi_meas, d;
   logic [3:0] lg;
   logic [31:0] m;
   rsc_ctl_t rx_ctl;
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   logic [7:0] rst_tab [9] = '{8'h38, 8'h18, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] wa [8] = '{8'h11, 8'h12, 8'h13, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19};
   logic [7:0] wv [8] = '{8'h7C, 8'hD6, 8'h05, 8'h9C, 8'hA5, 8'h3C, 8'h81, 8'hF0};
   logic [3:0] step_tab [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC};
   localparam logic [31:0] PAT = 32'h9E3B5A17;
   rsc_regs rsc_regs_i (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rssi_meas(rssi_meas), .rx_bit_valid(rx_bit_valid),
      .rx_bit_value(rx_bit_value), .rx_ctl(rx_ctl), .sync_match(sync_match), .cutoff_code_illegal(cutoff_code_illegal));
   rsc_host_model rsc_host_model_i (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .rx_bit_valid(rx_bit_valid), .rx_bit_value(rx_bit_value));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         n_errors++;
      end
   endtask
   task automatic summarize;
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // 100 ns clock
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   // hang guard, far above the few hundred cycles the sequence needs
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         summarize();
      end
   end
   initial begin
      reset = 1'b1;
      rssi_meas = 8'h5A;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      // reset values across the map; signal strength has none
      for (int i = 0; i < 9; i++) begin
         if (i != 3) begin
            rsc_host_model_i.rd(8'h11 + 8'(i), d);
            chk(d, rst_tab[i]);
         end
      end
      chk({rx_ctl.poly_center_freq_sel, rx_ctl.keying_step_half_db}, 8'h31);
      chk({6'h0, rx_ctl.poly_filter_on, rx_ctl.bit_synchronizer_off}, 8'h00);
      // live measurement, writes to it dropped
      rsc_host_model_i.rd(RSC_OFS_RSSI, d);
      chk(d, 8'h5A);
      rssi_meas <= 8'hC3;
      rsc_host_model_i.wr(RSC_OFS_RSSI, 8'h00);
      rsc_host_model_i.rd(RSC_OFS_RSSI, d);
      chk(d, 8'hC3);
      // write and read back every writable place
      foreach (wa[i]) begin
         rsc_host_model_i.wr(wa[i], wv[i]);
         rsc_host_model_i.rd(wa[i], d);
         chk(d, wv[i]);
      end
      // a zero write to the reserved register must not land; unmapped place reads zero
      rsc_host_model_i.wr(RSC_OFS_RESV, 8'h00);
      rsc_host_model_i.rd(RSC_OFS_RESV, d);
      chk(d, 8'h05);
      rsc_host_model_i.wr(8'h20, 8'hFF);
      rsc_host_model_i.rd(8'h20, d);
      chk(d, 8'h00);
      // every step, period and cutoff code, reserved cutoffs included
      for (int c = 0; c < 8; c++) begin
         rsc_host_model_i.wr(RSC_OFS_OOK_CFG, {c[2:0], c[2:0], c[1:0]});
         @(posedge mclk);
         #1 lg = {2'h0, c[1:0]} + {3'h0, c[2]};
         chk({4'h0, rx_ctl.keying_step_half_db}, {4'h0, step_tab[c]});
         chk({rx_ctl.keying_period_log2, rx_ctl.keying_threshold_period, rx_ctl.keying_period_is_multi},
            {lg, c[2:0], c[2]});
         chk({7'h0, cutoff_code_illegal}, {7'h0, ^c[1:0]});
         chk({7'h0, rx_ctl.keying_average_wide}, {7'h0, c[1:0] == 2'h3});
      end
      // store the reference pattern first; the bank still holds the read-back values otherwise
      for (int j = 0; j < 4; j++) begin
         rsc_host_model_i.wr(RSC_OFS_PAT_B3 + 8'(j), PAT[31 - 8 * j -: 8]);
      end
      // each length with exactly its tolerance in flipped bits, then one flip too many
      for (int k = 0; k < 4; k++) begin
         rsc_host_model_i.wr(RSC_OFS_SYNC_CTL, {3'b001, k[1:0], k[1:0], 1'b0});
         for (int f = 0; f < 2; f++) begin
            m = (32'h1 << (k + f)) - 32'h1;
            rsc_host_model_i.send((PAT >> (24 - 8 * k)) ^ m, 8 * (k + 1));
            #1 chk({7'h0, sync_match}, {7'h0, f == 0});
         end
      end
      // exact pattern with recognition off
      rsc_host_model_i.wr(RSC_OFS_SYNC_CTL, 8'h18);
      rsc_host_model_i.send(PAT, 32);
      #1 chk({7'h0, sync_match}, 8'h00);
      summarize();
   end
endmodule
`default_nettype wire
